/* hdl/ulpi_access_pkg.sv */
// Constants and carrier types for the ULPI command decoder and register sequencer
package ulpi_access_pkg;

   // Command class in bits [7:6] of the transmit command byte
   localparam logic [1:0] CLASS_SPECIAL = 2'h0;
   localparam logic [1:0] CLASS_TRANSMIT = 2'h1;
   localparam logic [1:0] CLASS_REG_WRITE = 2'h2;
   localparam logic [1:0] CLASS_REG_READ = 2'h3;

   // Position of the class field within the command byte
   localparam int CLASS_MSB = 7;
   localparam int CLASS_LSB = 6;

   // Lower six bits that escape to an extended address
   localparam logic [5:0] EXT_ADDR_ESCAPE = 6'h2f;
   localparam logic [5:0] NOPID_CODE = 6'h00;
   localparam logic [1:0] PID_PREFIX = 2'h0;
   localparam logic [7:0] BUS_IDLE = 8'h00;

   // Values after reset
   localparam logic [7:0] DATA_OUT_RESET = 8'h00;
   localparam logic [7:0] ADDR_RESET = 8'h00;
   localparam logic [3:0] PID_RESET = 4'h0;

   // Register array geometry
   localparam int ADDR_WIDTH = 8;
   localparam int DATA_WIDTH = 8;
   localparam int REG_DEPTH = 256;

   // Cycles from command on bus to NXT high
   localparam int NXT_DELAY_CYCLES = 2;

   typedef enum logic [9:0]
   {
      ST_IDLE = 10'h001,
      ST_CMD = 10'h002,
      ST_WR_ADDR = 10'h004,
      ST_WR_DATA = 10'h008,
      ST_WR_STOP = 10'h010,
      ST_RD_ADDR = 10'h020,
      ST_RD_TURN = 10'h040,
      ST_RD_DRIVE = 10'h080,
      ST_RD_BACK = 10'h100,
      ST_TX = 10'h200
   } seq_state_e;

   // Transmit start handed to the transmit path
   typedef struct packed
   {
      logic start;
      logic has_pid;
      logic [3:0] pid;
   } tx_start_s;

   // Pins that the device drives toward the link
   typedef struct packed
   {
      logic dir;
      logic nxt;
      logic [7:0] data_o;
      logic data_oe;
   } ulpi_out_s;

endpackage : ulpi_access_pkg

/* hdl/ulpi_reg_mem.sv */
// Register array for the ULPI register sequencer, one write port, registered read
`timescale 1ns/1ps
module ulpi_reg_mem #(
   parameter int AW = 8,
   parameter int DW = 8,
   parameter int DEPTH = 256
)(
   input wire logic core_clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);
   logic [DW-1:0] mem_q [DEPTH];

   // No reset and no mode input: contents hold through every power or serial mode
   always_ff @(posedge core_clk)
   begin
      if (wr_en)
      begin
         mem_q[wr_addr] <= wr_data;
      end
      rd_data <= mem_q[rd_addr];
   end
endmodule : ulpi_reg_mem

/* hdl/ulpi_register_access.sv */
// Device-side ULPI transmit command decoder and register access sequencer
`timescale 1ns/1ps
module ulpi_register_access
   import ulpi_access_pkg::*;
#(
   parameter int AW = ADDR_WIDTH,
   parameter int DW = DATA_WIDTH,
   parameter int DEPTH = REG_DEPTH
)(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] data_i,
   input wire logic stp,
   input wire logic tx_done,
   output ulpi_access_pkg::ulpi_out_s ulpi_o,
   output ulpi_access_pkg::tx_start_s tx_o,
   output logic busy
);
   import ulpi_access_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // State and storage

   seq_state_e state_q;
   seq_state_e state_d;
   logic [7:0] cmd_q;
   logic [AW-1:0] addr_q;
   logic [AW-1:0] addr_d;
   logic [DW-1:0] wr_data_q;
   logic wr_pend_q;
   logic dir_q;
   logic dir_d;
   logic nxt_q;
   logic nxt_d;
   logic oe_q;
   logic oe_d;
   logic [7:0] dout_q;
   logic [7:0] dout_d;
   tx_start_s tx_q;
   tx_start_s tx_d;
   logic busy_q;
   logic [DW-1:0] rd_data;
   logic mem_wr;

   ////////////////////////////////////////////////////////////////////////////////
   // Command decode, continuous

   wire logic [1:0] cmd_class = data_i[CLASS_MSB:CLASS_LSB];
   wire logic cmd_nonidle = (data_i != BUS_IDLE);
   wire logic is_tx = (cmd_class == CLASS_TRANSMIT);
   wire logic is_wr = (cmd_class == CLASS_REG_WRITE);
   wire logic is_rd = (cmd_class == CLASS_REG_READ);
   wire logic held_ext = (cmd_q[5:0] == EXT_ADDR_ESCAPE);
   wire logic held_wr = (cmd_q[CLASS_MSB:CLASS_LSB] == CLASS_REG_WRITE);
   wire logic held_rd = (cmd_q[CLASS_MSB:CLASS_LSB] == CLASS_REG_READ);
   wire logic held_tx = (cmd_q[CLASS_MSB:CLASS_LSB] == CLASS_TRANSMIT);
   wire logic tx_nopid = (cmd_q[5:0] == NOPID_CODE);
   wire logic tx_pid = (cmd_q[5:4] == PID_PREFIX) && !tx_nopid;
   // immediate address from low six bits
   wire logic [AW-1:0] imm_addr = AW'(cmd_q[5:0]);

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer

   always_comb
   begin
      state_d = state_q;
      addr_d = addr_q;
      dir_d = 1'b0;
      nxt_d = 1'b0;
      oe_d = 1'b0;
      dout_d = DATA_OUT_RESET;
      tx_d = '0;
      unique case (state_q)
         ST_IDLE:
         begin
            // commands are only looked at while direction is low
            if (cmd_nonidle && (is_tx || is_wr || is_rd))
            begin
               state_d = ST_CMD;
            end
         end
         ST_CMD:
         begin
            // NXT high two cycles after the command
            nxt_d = 1'b1;
            // 2Fh never addresses a register directly
            if (held_ext)
            begin
               state_d = held_wr ? ST_WR_ADDR : (held_rd ? ST_RD_ADDR : ST_TX);
            end
            else
            begin
               addr_d = imm_addr;
               state_d = held_wr ? ST_WR_DATA : (held_rd ? ST_RD_ADDR : ST_TX);
            end
            if (held_tx)
            begin
               state_d = ST_TX;
            end
         end
         ST_WR_ADDR:
         begin
            nxt_d = 1'b1;
            addr_d = AW'(data_i);
            state_d = ST_WR_DATA;
         end
         ST_WR_DATA:
         begin
            // data taken on this edge, NXT drops next
            state_d = ST_WR_STOP;
         end
         ST_WR_STOP:
         begin
            // link idle now on the bus, back to decoding
            state_d = ST_IDLE;
         end
         ST_RD_ADDR:
         begin
            // capture extended address, then turn the bus
            if (held_ext)
            begin
               addr_d = AW'(data_i);
            end
            // direction rises after NXT
            // Immediate reads pass here too, so NXT always stands alone first
            dir_d = 1'b1;
            state_d = ST_RD_TURN;
         end
         ST_RD_TURN:
         begin
            dir_d = 1'b1;
            oe_d = 1'b1;
            dout_d = rd_data;
            state_d = ST_RD_DRIVE;
         end
         ST_RD_DRIVE:
         begin
            // read value stood one cycle, now release direction
            state_d = ST_RD_BACK;
         end
         ST_RD_BACK:
         begin
            // turnaround before the link drives idle
            state_d = ST_IDLE;
         end
         ST_TX:
         begin
            tx_d.start = 1'b0;
            if (tx_done || stp)
            begin
               state_d = ST_IDLE;
            end
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
      // One-cycle transmit start, with PID when present
      if ((state_q == ST_CMD) && held_tx)
      begin
         tx_d.start = tx_nopid || tx_pid;
         tx_d.has_pid = tx_pid;
         tx_d.pid = cmd_q[3:0];
      end
   end

   // commit on the cycle STP is released
   assign mem_wr = wr_pend_q && !stp;

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state_q <= ST_IDLE;
         cmd_q <= BUS_IDLE;
         addr_q <= ADDR_RESET;
         wr_data_q <= DATA_OUT_RESET;
         wr_pend_q <= 1'b0;
         dir_q <= 1'b0;
         nxt_q <= 1'b0;
         oe_q <= 1'b0;
         dout_q <= DATA_OUT_RESET;
         tx_q <= '0;
         busy_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         addr_q <= addr_d;
         dir_q <= dir_d;
         nxt_q <= nxt_d;
         oe_q <= oe_d;
         dout_q <= dout_d;
         tx_q <= tx_d;
         busy_q <= (state_d != ST_IDLE);
         if (state_q == ST_IDLE)
         begin
            cmd_q <= data_i;
         end
         // capture write data while NXT accepted it
         if (state_q == ST_WR_DATA)
         begin
            wr_data_q <= data_i;
         end
         // hold the write until STP falls
         if (state_q == ST_WR_STOP)
         begin
            wr_pend_q <= 1'b1;
         end
         else if (mem_wr)
         begin
            wr_pend_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register array and pins

   // storage has no reset and no mode dependence
   ulpi_reg_mem #(
      .AW(AW),
      .DW(DW),
      .DEPTH(DEPTH)
   ) u_mem (
      .core_clk(core_clk),
      .wr_en(mem_wr),
      .wr_addr(addr_q),
      .wr_data(wr_data_q),
      .rd_addr(addr_d),
      .rd_data(rd_data)
   );

   // direction only rises in read states, so writes keep it low
   assign ulpi_o.dir = dir_q;
   assign ulpi_o.nxt = nxt_q;
   assign ulpi_o.data_o = dout_q;
   assign ulpi_o.data_oe = oe_q;
   assign tx_o = tx_q;
   assign busy = busy_q;

endmodule : ulpi_register_access

/* test/tb.sv */
// Self-checking bench for the ULPI register access sequencer
`timescale 1ns/1ps
module tb;
   import ulpi_access_pkg::*;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic tx_done = 1'b0;
   logic stp;
   logic [7:0] data_i;
   ulpi_out_s ulpi_o;
   tx_start_s tx_o;
   logic busy;
   logic ok;
   logic e;
   logic [7:0] a;
   logic [7:0] mem [256];
   int err_count = 0;
   int checks_done = 0;
   always #50 core_clk = ~core_clk;
   ulpi_register_access i_ulpi_register_access (.core_clk(core_clk), .reset(reset),
      .data_i(data_i), .stp(stp), .tx_done(tx_done), .ulpi_o(ulpi_o), .tx_o(tx_o), .busy(busy));
   ulpi_link_model i_ulpi_link_model (.core_clk(core_clk), .ulpi_o(ulpi_o), .busy(busy),
      .data_i(data_i), .stp(stp));
   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic hang(input logic done);
      chk("handshake", 8'h01, {7'h00, done});
      if (done !== 1'b1)
         summarize();
   endtask : hang
   function automatic logic [7:0] tx_exp(input logic [3:0] p);
      return {2'h0, 1'b1, p != NOPID_CODE[3:0], p};
   endfunction : tx_exp
   // Write then read back, each access immediate or extended
   task automatic wr_rd(input logic we, input logic re, input logic [7:0] adr, input logic [7:0] d);
      logic [7:0] got;
      i_ulpi_link_model.wr(we, adr, d, ok);
      hang(ok);
      mem[adr] = d;
      i_ulpi_link_model.rd(re, adr, got, ok);
      hang(ok);
      chk("read data", mem[adr], got);
   endtask : wr_rd
   initial
   begin
      void'($urandom(52));
      repeat (16) @(negedge core_clk);
      chk("reset flags", 8'h00, {3'h0, ulpi_o.dir, ulpi_o.nxt, ulpi_o.data_oe, tx_o.start, busy});
      reset = 1'b0;
      i_ulpi_link_model.drv = 8'h15;
      repeat (4) @(negedge core_clk);
      chk("ignored byte", 8'h00, {6'h00, busy, ulpi_o.nxt});
      i_ulpi_link_model.drv = BUS_IDLE;
      wr_rd(1'b0, 1'b1, 8'h05, 8'ha5);
      wr_rd(1'b1, 1'b0, 8'h3f, 8'h5a);
      wr_rd(1'b1, 1'b1, 8'h2f, 8'h3c);
      wr_rd(1'b1, 1'b1, 8'hff, 8'h81);
      repeat (30)
      begin
         a = 8'($urandom);
         e = a[7:6] != 2'h0 || a[5:0] == EXT_ADDR_ESCAPE;
         wr_rd(e || 1'($urandom), e || 1'($urandom), a, 8'($urandom));
      end
      for (int p = 0; p < 16; p++)
      begin
         i_ulpi_link_model.tx(4'(p), ok);
         hang(ok);
         chk("tx start", tx_exp(4'(p)), {2'h0, tx_o.start, tx_o.has_pid, tx_o.pid});
         // Odd codes end the transmit with STP, even ones from the transmit path
         if (p[0])
            i_ulpi_link_model.stp = 1'b1;
         else
            tx_done = 1'b1;
         @(negedge core_clk);
         i_ulpi_link_model.stp = 1'b0;
         tx_done = 1'b0;
         chk("tx end", 8'h00, {7'h00, busy});
      end
      summarize();
   end
endmodule : tb

/* test/ulpi_access_properties.sv */
// Port assertions for the ULPI register access sequencer
`timescale 1ns/1ps
module ulpi_access_properties
   import ulpi_access_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] data_i,
   input ulpi_access_pkg::ulpi_out_s ulpi_o,
   input ulpi_access_pkg::tx_start_s tx_o,
   input wire logic busy
);
   wire logic [3:0] pid_in = data_i[3:0];
   wire logic wr_cmd = !busy && data_i[7:6] == CLASS_REG_WRITE;
   wire logic rd_cmd = !busy && data_i[7:6] == CLASS_REG_READ;
   wire logic tx_cmd = !busy && data_i[7:4] == {CLASS_TRANSMIT, PID_PREFIX};
   wire logic esc = data_i[5:0] == EXT_ADDR_ESCAPE;
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////
   turn_undriven_a: assert property ($changed(ulpi_o.dir) |-> !ulpi_o.data_oe)
      else $error("bus driven in turnaround");
   drive_owned_a: assert property (ulpi_o.data_oe |-> ulpi_o.dir && $past(ulpi_o.dir))
      else $error("bus driven without ownership");
   read_window_a: assert property ($rose(ulpi_o.dir) |->
      ($past(ulpi_o.nxt) && !ulpi_o.nxt) ##1 ulpi_o.data_oe ##1 !ulpi_o.dir)
      else $error("read window wrong");
   write_nxt_a: assert property (wr_cmd && !esc |=>
      !ulpi_o.nxt ##1 ulpi_o.nxt ##1 !ulpi_o.nxt)
      else $error("write handshake wrong");
   ext_write_nxt_a: assert property (wr_cmd && esc |=>
      !ulpi_o.nxt ##1 ulpi_o.nxt [*2] ##1 !ulpi_o.nxt)
      else $error("extended write handshake wrong");
   write_dir_low_a: assert property (wr_cmd |-> !ulpi_o.dir [*6])
      else $error("direction rose in write");
   read_turn_a: assert property (rd_cmd |=>
      !ulpi_o.dir ##1 (ulpi_o.nxt && !ulpi_o.dir) ##1 ulpi_o.dir)
      else $error("read turnaround late");
   tx_start_a: assert property (tx_cmd |-> ##2 (tx_o.start &&
      tx_o.pid == $past(pid_in, 2) && tx_o.has_pid == ($past(pid_in, 2) != 4'h0)))
      else $error("transmit start wrong");
endmodule : ulpi_access_properties
bind ulpi_register_access ulpi_access_properties i_props (.core_clk(core_clk), .reset(reset),
   .data_i(data_i), .ulpi_o(ulpi_o), .tx_o(tx_o), .busy(busy));

/* test/ulpi_link_model.sv */
// Link-side model driving commands, data and stop onto the shared bus
`timescale 1ns/1ps
module ulpi_link_model
   import ulpi_access_pkg::*;
(
   input wire logic core_clk,
   input ulpi_access_pkg::ulpi_out_s ulpi_o,
   input wire logic busy,
   output logic [7:0] data_i,
   output logic stp = 1'b0
);
   logic [7:0] drv = 8'h00;
   logic [7:0] flt_q = 8'h00;
   logic dir_q = 1'b0;
   always @(posedge core_clk)
   begin
      dir_q <= ulpi_o.dir;
      flt_q <= ~data_i;
   end
   // turnaround left undriven
   // A released bus toggles so a stale value can never pass as data
   always_comb
   begin
      if (ulpi_o.data_oe)
         data_i = ulpi_o.data_o;
      else if (!ulpi_o.dir && !dir_q)
         data_i = drv;
      else
         data_i = flt_q;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic start(input logic [7:0] cmd, output logic ok);
      for (int n = 0; n < 16 && (ulpi_o.dir || busy); n++)
         @(negedge core_clk);
      drv = cmd;
      ok = 1'b0;
      for (int n = 0; n < 8 && !ok; n++)
      begin
         @(negedge core_clk);
         ok = ulpi_o.nxt;
      end
   endtask : start
   task automatic wr(input logic e, input logic [7:0] a, input logic [7:0] d, output logic ok);
      start({CLASS_REG_WRITE, e ? EXT_ADDR_ESCAPE : a[5:0]}, ok);
      if (e)
      begin
         drv = a;
         @(negedge core_clk);
      end
      drv = d;
      @(negedge core_clk);
      drv = BUS_IDLE;
      stp = 1'b1;
      @(negedge core_clk);
      stp = 1'b0;
   endtask : wr
   task automatic rd(input logic e, input logic [7:0] a, output logic [7:0] d, output logic ok);
      start({CLASS_REG_READ, e ? EXT_ADDR_ESCAPE : a[5:0]}, ok);
      if (e)
         drv = a;
      for (int n = 0; n < 8 && !ulpi_o.data_oe; n++)
         @(negedge core_clk);
      ok = ok && ulpi_o.data_oe;
      d = data_i;
      drv = BUS_IDLE;
   endtask : rd
   task automatic tx(input logic [3:0] p, output logic ok);
      start({CLASS_TRANSMIT, PID_PREFIX, p}, ok);
      drv = BUS_IDLE;
   endtask : tx
endmodule : ulpi_link_model
